/* File: src/spe_memfunc.sv */
// memory-function layer: scratchpad, address registers, eeprom array, receive fifo
//
// Behaviour
// RULE1: write loads ending offset with T[2:0], advances per further full byte.
// RULE2: partial-write flag, status bit 5, marks scratchpad contents invalid.
// RULE3: status bits 3, 4 and 6 always read zero.
// RULE4: copy-done flag set after copy, cleared by new scratchpad data.
// RULE5: any write accepted; copy needs T[2:0]=000b and eight full bytes.
// RULE6: write command takes address low then high, data from offset T[2:0].
// RULE7: only complete bytes stored; trailing fragment dropped, offset untouched.
// RULE8: write crc cleared, then command, address bytes, data as received.
// RULE9: at offset 111b master may read inverted crc-16 in 16 slots.
// RULE10: write-protected target loads scratchpad with stored memory data.
// RULE11: eprom-mode target loads AND of received and stored byte.
// RULE12: read scratchpad sends address low, high, status, stored data.
// RULE13: inverted crc of sent bytes follows, then all ones.
// RULE14: copy authorization compared with address low, high, status in order.
// RULE15: matching valid copy sets copy-done and writes eight bytes to row.
// RULE16: after programming, read slots return alternating zero/one until reset.
// RULE17: partial or copy-protected target: no copy, copy-done stays cleared.
// RULE18: disturbed copy answers FFh bytes until bus reset.
// RULE19: read memory returns bytes up to 008Fh, ones beyond.
// RULE20: read memory leaves address, status and scratchpad unchanged.
// RULE21: standard speed default; fast only while speed flag set.
// RULE22: page protection bytes: 55h write protect, AAh eprom, else open.
// RULE23: copy protection 55h/AAh blocks copies to register rows, protected pages.
// RULE24: all bytes travel least significant bit first.
// RULE25: programming interval is a parameter; no command until it ends and reset.
`timescale 1ns/1ps
`default_nettype none

module spe_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         flush,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } spe_fifo_t;

    spe_fifo_t    q, d;
    logic [W-1:0] mem [D];
    logic         push, pop;

    assign in_ready  = (q.cnt != (AW+1)'(D));
    assign out_valid = (q.cnt != '0);
    assign out_data  = mem[q.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        d = q;
        if (flush) begin
            d = '0;
        end else begin
            if (push) d.wp = q.wp + 1'b1;
            if (pop) d.rp = q.rp + 1'b1;
            d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // storage carries no reset; contents are only read while counted valid
    always_ff @(posedge clk) begin
        if (push && !flush) mem[q.wp] <= in_data;
    end
endmodule

module spe_memfunc
    import spe_pkg::*;
#(
    parameter int unsigned PROG_CYCLES = spe_pkg::PROG_CYCLES_DEF
) (
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic       func_start,
    input  wire logic       bus_reset,
    input  wire logic       fast_speed_in,
    input  wire logic       rx_valid,
    input  wire logic       rx_bit,
    output logic            rx_ready,
    input  wire logic       slot_req,
    output logic            tx_bit,
    output logic            tx_valid,
    input  wire logic       power_loss,
    input  wire logic       copy_fault,
    output logic [7:0]      target_addr_low,
    output logic [7:0]      target_addr_high,
    output logic [7:0]      ending_offset_status,
    output logic            fast_speed_flag,
    output logic            busy
);
    import spe_pkg::*;

    typedef struct packed {
        spe_state_t     st;
        spe_txm_t       txm;
        logic [7:0]     ta_lo;
        logic [7:0]     ta_hi;
        logic [2:0]     eo;
        logic           pf;
        logic           aa;
        logic           first;
        logic           full_row;
        logic [7:0][7:0] sp;
        logic [15:0]    crc;
        logic [7:0]     txsh;
        logic [2:0]     txcnt;
        logic [2:0]     ph;
        logic [8:0]     ptr;
        logic [1:0]     acnt;
        logic           auth_ok;
        logic [31:0]    pcnt;
        logic [3:0]     cpi;
        logic           fail;
        logic           rst_seen;
        logic           fast;
        logic           tx_bit;
        logic           tx_valid;
        logic [6:0]     rxsh;
        logic [2:0]     rxcnt;
    } spe_core_t;

    spe_core_t  q, n;
    logic [7:0] mem [MEM_BYTES];
    logic       mem_we;
    logic [7:0] mem_wa;
    logic [7:0] mem_wd;
    logic       f_in_valid, f_out_valid, f_out_ready, f_flush;
    logic [7:0] f_in_data, f_out_data;

    function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[0] ^ b[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    function automatic logic is_lock(input logic [7:0] v);
        return (v == PROT_WRITE) || (v == PROT_EPROM);
    endfunction

    function automatic logic [7:0] es_byte(input logic aa, input logic pf, input logic [2:0] eo);
        logic [7:0] r;
        r = '0;                                          // RULE3
        r[ES_AA_BIT] = aa;
        r[ES_PF_BIT] = pf;
        r[2:0] = eo;
        return r;
    endfunction

    function automatic logic [7:0] mem_rd(input logic [8:0] a);
        return (a < MEM_TOP) ? mem[a[7:0]] : BYTE_ONES;  // RULE19
    endfunction

    function automatic logic [7:0] page_ctl(input logic [7:0] a);
        return mem[PROT_BASE + {6'h00, a[6:5]}];
    endfunction

    // target-aware scratchpad load for one received byte
    function automatic logic [7:0] sp_load(input logic [7:0] hi, input logic [7:0] a,
                                           input logic [7:0] b);
        logic [7:0] cur;
        logic       wp;
        logic       ep;
        cur = mem_rd({1'b0, a});
        wp = 1'b0;
        ep = 1'b0;
        if (hi != 8'h00 || {1'b0, a} >= MEM_TOP) begin
            wp = 1'b0;
        end else if (a < PROT_BASE) begin
            wp = (page_ctl(a) == PROT_WRITE);              // RULE22
            ep = (page_ctl(a) == PROT_EPROM);              // RULE22
        end else if (a <= COPY_PROT) begin
            wp = is_lock(cur);
        end else if (a == FACTORY_BYTE) begin
            wp = 1'b1;
        end else begin
            wp = (mem[FACTORY_BYTE] == PROT_EPROM);
        end
        if (wp) return cur;                              // RULE10
        if (ep) return cur & b;                          // RULE11
        return b;
    endfunction

    assign f_flush    = bus_reset || func_start;
    assign f_in_valid = rx_valid && (q.rxcnt == 3'h7);
    assign f_in_data  = {rx_bit, q.rxsh};                // RULE24
    // bytes wait in the fifo while idle or programming, so the link sees back-pressure
    assign f_out_ready = (q.st != S_IDLE) && (q.st != S_PROG);

    spe_fifo #(.W(FIFO_WIDTH), .D(FIFO_DEPTH)) u_rx_fifo (
        .clk       (mclk),
        .rst_n     (resetn),
        .flush     (f_flush),
        .in_valid  (f_in_valid),
        .in_ready  (rx_ready),
        .in_data   (f_in_data),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out_data)
    );

    always_comb begin
        logic [7:0]  b;
        logic [2:0]  off;
        logic [15:0] nc;
        logic [7:0]  exp;
        logic        ok;
        logic        cprot;
        b = f_out_data;
        off = q.first ? q.eo : q.eo + 3'h1;
        nc = crc16_byte(q.crc, b);
        exp = '0;
        ok = 1'b0;
        cprot = 1'b0;
        n = q;
        n.tx_valid = 1'b0;
        mem_we = 1'b0;
        mem_wa = '0;
        mem_wd = '0;

        // bit assembly, lsb first; a fragment dies with the next start or reset
        if (rx_valid && rx_ready) begin
            n.rxsh = {rx_bit, q.rxsh[6:1]};              // RULE24
            n.rxcnt = q.rxcnt + 3'h1;
        end
        if (f_flush) n.rxcnt = '0;                       // RULE7

        unique case (q.st)
            S_IDLE: begin
                if (func_start) begin
                    n.st = S_CMD;
                    n.fast = fast_speed_in;              // RULE21
                end
            end
            S_CMD: begin
                if (f_out_valid) begin
                    n.txcnt = '0;
                    n.ph = '0;
                    if (b == CMD_WRITE_SP) begin
                        n.st = S_WA_LO;
                        n.crc = crc16_byte(16'h0000, b);  // RULE8
                    end else if (b == CMD_READ_SP) begin
                        n.st = S_TX;
                        n.txm = TX_RSCR;
                        n.txsh = q.ta_lo;                // RULE12
                        n.crc = crc16_byte(16'h0000, q.ta_lo);
                    end else if (b == CMD_COPY_SP) begin
                        n.st = S_AUTH;
                        n.acnt = '0;
                        n.auth_ok = 1'b1;
                    end else if (b == CMD_READ_MEM) begin
                        n.st = S_RA_LO;
                    end else begin
                        n.st = S_TX;
                        n.txm = TX_ONES;
                        n.txsh = BYTE_ONES;
                    end
                end
            end
            S_WA_LO: begin
                if (f_out_valid) begin
                    n.ta_lo = b;                         // RULE6
                    n.crc = nc;                          // RULE8
                    n.st = S_WA_HI;
                end
            end
            S_WA_HI: begin
                if (f_out_valid) begin
                    n.ta_hi = b;                         // RULE6
                    n.crc = nc;
                    n.eo = q.ta_lo[2:0];                 // RULE1
                    n.first = 1'b1;
                    n.pf = 1'b1;                         // RULE2
                    n.full_row = 1'b0;
                    n.st = S_WDATA;
                end
            end
            S_WDATA: begin
                if (f_out_valid) begin
                    n.sp[off] = sp_load(q.ta_hi, {q.ta_lo[7:3], off}, b);
                    n.eo = off;                          // RULE1
                    n.first = 1'b0;
                    n.aa = 1'b0;                         // RULE4
                    n.crc = nc;                          // RULE8
                    if (off == EO_LAST) begin
                        n.pf = 1'b0;
                        n.full_row = (q.ta_lo[2:0] == 3'h0);  // RULE5
                        n.st = S_TX;                     // RULE9
                        n.txm = TX_WCRC;
                        n.txsh = ~nc[7:0];
                        n.txcnt = '0;
                        n.ph = '0;
                    end
                end
            end
            S_AUTH: begin
                if (f_out_valid) begin
                    unique case (q.acnt)
                        2'h0:    exp = q.ta_lo;
                        2'h1:    exp = q.ta_hi;
                        default: exp = es_byte(q.aa, q.pf, q.eo);
                    endcase
                    n.auth_ok = q.auth_ok && (b == exp); // RULE14
                    n.acnt = q.acnt + 2'h1;
                    if (q.acnt == 2'h2) begin
                        cprot = is_lock(mem[COPY_PROT]) &&
                                (q.ta_lo >= PROT_BASE || page_ctl(q.ta_lo) == PROT_WRITE);  // RULE23
                        ok = n.auth_ok && q.ta_hi == 8'h00 && {1'b0, q.ta_lo} < MEM_TOP &&
                             q.full_row && !q.pf && !cprot;       // RULE15 RULE17 RULE5
                        n.txcnt = '0;
                        if (ok) begin
                            n.aa = 1'b1;                 // RULE15
                            n.st = S_PROG;
                            n.cpi = '0;
                            n.pcnt = '0;
                            n.fail = 1'b0;
                            n.rst_seen = 1'b0;
                        end else begin
                            n.st = S_TX;                 // RULE17
                            n.txm = TX_ONES;
                            n.txsh = BYTE_ONES;
                        end
                    end
                end
            end
            S_PROG: begin
                // one row byte per cycle; a disturbance stops the row partly written
                if (q.cpi < 4'h8 && !q.fail && !copy_fault) begin
                    mem_we = 1'b1;                       // RULE15
                    mem_wa = {q.ta_lo[7:3], q.cpi[2:0]};
                    mem_wd = q.sp[q.cpi[2:0]];
                    n.cpi = q.cpi + 4'h1;
                end
                if (copy_fault) n.fail = 1'b1;           // RULE18
                if (bus_reset) n.rst_seen = 1'b1;
                n.pcnt = q.pcnt + 32'h1;
                if (q.pcnt >= PROG_CYCLES - 1) begin     // RULE25
                    n.txcnt = '0;
                    if (q.rst_seen || bus_reset) begin
                        n.st = S_IDLE;
                    end else begin
                        n.st = S_TX;
                        n.txm = (q.fail || copy_fault) ? TX_ONES : TX_ALT;  // RULE16 RULE18
                        n.txsh = (q.fail || copy_fault) ? BYTE_ONES : BYTE_ALT;
                    end
                end
            end
            S_RA_LO: begin
                if (f_out_valid) begin
                    n.ptr = {1'b0, b};                   // RULE20
                    n.st = S_RA_HI;
                end
            end
            S_RA_HI: begin
                if (f_out_valid) begin
                    n.st = S_TX;
                    n.txcnt = '0;
                    n.txm = (b == 8'h00) ? TX_RMEM : TX_ONES;
                    n.txsh = (b == 8'h00) ? mem_rd(q.ptr) : BYTE_ONES;  // RULE19
                end
            end
            S_TX: begin
                if (slot_req) begin
                    n.tx_bit = q.txsh[0];                // RULE24
                    n.tx_valid = 1'b1;
                    n.txsh = {1'b1, q.txsh[7:1]};
                    n.txcnt = q.txcnt + 3'h1;
                    if (q.txcnt == 3'h7) begin
                        unique case (q.txm)
                            TX_WCRC: begin
                                n.txsh = ~q.crc[15:8];   // RULE9
                                n.txm = TX_ONES;
                            end
                            TX_RSCR: begin
                                unique case (q.ph)
                                    3'h0: begin
                                        n.txsh = q.ta_hi;
                                        n.crc = crc16_byte(q.crc, q.ta_hi);
                                        n.ph = 3'h1;
                                    end
                                    3'h1: begin
                                        n.txsh = es_byte(q.aa, q.pf, q.eo);
                                        n.crc = crc16_byte(q.crc, n.txsh);
                                        n.ptr = {6'h00, q.ta_lo[2:0]};
                                        n.ph = 3'h2;
                                    end
                                    3'h2: begin
                                        n.txsh = q.sp[q.ptr[2:0]];       // RULE12
                                        n.crc = crc16_byte(q.crc, n.txsh);
                                        n.ptr = q.ptr + 9'h1;
                                        if (q.ptr[2:0] == q.eo) n.ph = 3'h3;
                                    end
                                    3'h3: begin
                                        n.txsh = ~q.crc[7:0];            // RULE13
                                        n.ph = 3'h4;
                                    end
                                    default: begin
                                        n.txsh = ~q.crc[15:8];           // RULE13
                                        n.txm = TX_ONES;
                                    end
                                endcase
                            end
                            TX_RMEM: begin
                                n.ptr = q.ptr + 9'h1;
                                n.txsh = (q.ptr >= READ_END) ? BYTE_ONES : mem_rd(q.ptr + 9'h1);
                                if (q.ptr >= READ_END) n.txm = TX_ONES;  // RULE19
                            end
                            TX_ALT:  n.txsh = BYTE_ALT;  // RULE16
                            TX_ONES: n.txsh = BYTE_ONES; // RULE13 RULE18
                        endcase
                    end
                end
            end
        endcase

        // a bus reset ends any exchange except a running programming interval
        if (bus_reset && q.st != S_PROG) n.st = S_IDLE;  // RULE25
        if (power_loss) n.pf = 1'b1;                     // RULE2
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            q <= '0;
            q.st <= S_IDLE;
            q.txm <= TX_ONES;
            q.ta_lo <= TA_RESET;
            q.ta_hi <= TA_RESET;
            q.pf <= PF_RESET;
        end else begin
            q <= n;
        end
    end

    // the array stands in for the cells; reset models an erased part
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < MEM_BYTES; i++) mem[i] <= BYTE_ONES;
        end else if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    assign target_addr_low      = q.ta_lo;
    assign target_addr_high     = q.ta_hi;
    assign ending_offset_status = es_byte(q.aa, q.pf, q.eo);   // RULE3
    assign fast_speed_flag      = q.fast;
    assign busy                 = (q.st == S_PROG);
    assign tx_bit               = q.tx_bit;
    assign tx_valid             = q.tx_valid;
endmodule

`default_nettype wire

/* File: src/spe_pkg.sv */
// constants and types of the scratchpad eeprom memory-function block
package spe_pkg;
    // memory-function command codes
    localparam logic [7:0] CMD_WRITE_SP  = 8'h0F;
    localparam logic [7:0] CMD_READ_SP   = 8'hAA;
    localparam logic [7:0] CMD_COPY_SP   = 8'h55;
    localparam logic [7:0] CMD_READ_MEM  = 8'hF0;
    // protection codes
    localparam logic [7:0] PROT_WRITE    = 8'h55;
    localparam logic [7:0] PROT_EPROM    = 8'hAA;
    // address map
    localparam logic [7:0] PROT_BASE     = 8'h80;
    localparam logic [7:0] COPY_PROT     = 8'h84;
    localparam logic [7:0] FACTORY_BYTE  = 8'h85;
    localparam logic [8:0] MEM_TOP       = 9'h088;
    localparam logic [8:0] READ_END      = 9'h08F;
    localparam int         MEM_BYTES     = 136;
    // status byte fields and register reset values
    localparam int         ES_PF_BIT     = 5;
    localparam int         ES_AA_BIT     = 7;
    localparam logic [2:0] EO_LAST       = 3'h7;
    localparam logic       PF_RESET      = 1'b1;
    localparam logic [7:0] TA_RESET      = 8'h00;
    // fill patterns and crc
    localparam logic [7:0] BYTE_ONES     = 8'hFF;
    localparam logic [7:0] BYTE_ALT      = 8'hAA;
    localparam logic [15:0] CRC_POLY     = 16'hA001;
    // programming interval and receive fifo size
    localparam int         CLK_PERIOD_NS = 40;
    localparam int         PROG_TIME_NS  = 10000000;
    localparam int         PROG_CYCLES_DEF = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         FIFO_DEPTH    = 16;
    localparam int         FIFO_WIDTH    = 8;

    typedef enum logic [3:0] {
        S_IDLE, S_CMD, S_WA_LO, S_WA_HI, S_WDATA, S_AUTH, S_PROG, S_RA_LO, S_RA_HI, S_TX
    } spe_state_t;

    typedef enum logic [2:0] {
        TX_WCRC, TX_RSCR, TX_RMEM, TX_ALT, TX_ONES
    } spe_txm_t;
endpackage

/* File: verification/spe_memfunc_monitor.sv */
// assertion checker bound to the memory-function block
`timescale 1ns/1ps
`default_nettype none
module spe_memfunc_monitor #(
    parameter int unsigned PROG_CYCLES = 20
) (
    input wire logic       mclk,
    input wire logic       resetn,
    input wire logic       func_start,
    input wire logic       slot_req,
    input wire logic       tx_valid,
    input wire logic [7:0] target_addr_low,
    input wire logic [7:0] target_addr_high,
    input wire logic [7:0] ending_offset_status,
    input wire logic       fast_speed_flag,
    input wire logic       busy
);
    logic [31:0] busy_cnt_q;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) busy_cnt_q <= 32'h0;
        else busy_cnt_q <= busy ? busy_cnt_q + 32'h1 : 32'h0;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    tx_after_slot_a: assert property (tx_valid |-> $past(slot_req))
        else $error("answer bit without a read slot");
    es_zero_bits_a: assert property (ending_offset_status[6] == 1'b0
        && ending_offset_status[4:3] == 2'h0) else $error("unused status bits set");
    prog_len_a: assert property ($fell(busy) |-> busy_cnt_q == PROG_CYCLES)
        else $error("programming interval length wrong");
    aa_with_copy_a: assert property ($rose(ending_offset_status[7]) |-> busy)
        else $error("copy-done set without a copy");
    copy_needs_row_a: assert property ($rose(busy) |-> ending_offset_status[5] == 1'b0
        && ending_offset_status[2:0] == 3'h7) else $error("copy of an incomplete row");
    copy_aligned_a: assert property ($rose(busy) |-> target_addr_low[2:0] == 3'h0)
        else $error("copy to an unaligned target");
    addr_hold_a: assert property (busy |=> $stable({target_addr_high, target_addr_low}))
        else $error("target address moved while programming");
    speed_hold_a: assert property (!$stable(fast_speed_flag) |-> $past(func_start))
        else $error("speed flag changed outside a command start");
    cover property ($rose(busy));
    cover property ($fell(ending_offset_status[5]));
    cover property (tx_valid);
endmodule
bind spe_memfunc spe_memfunc_monitor #(.PROG_CYCLES(PROG_CYCLES)) mon (.mclk(mclk),
    .resetn(resetn), .func_start(func_start), .slot_req(slot_req), .tx_valid(tx_valid),
    .target_addr_low(target_addr_low), .target_addr_high(target_addr_high),
    .ending_offset_status(ending_offset_status), .fast_speed_flag(fast_speed_flag),
    .busy(busy));
`default_nettype wire

/* File: verification/spe_master_model.sv */
// bus master model: sends bits lsb first and issues read slots
`timescale 1ns/1ps
`default_nettype none
module spe_master_model (
    input wire logic mclk,
    output var logic rx_valid,
    output var logic rx_bit,
    input wire logic rx_ready,
    output var logic slot_req,
    input wire logic tx_bit,
    input wire logic tx_valid
);
    initial begin
        rx_valid = 1'b0;
        rx_bit = 1'b1;
        slot_req = 1'b0;
    end
    task automatic send(input logic [7:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge mclk);
            rx_valid = 1'b1;
            rx_bit = b[i];
            while (!rx_ready) @(negedge mclk);
            @(posedge mclk);
        end
        @(negedge mclk);
        rx_valid = 1'b0;
        rx_bit = 1'b1;
    endtask
    task automatic recv(output logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            @(negedge mclk);
            slot_req = 1'b1;
            @(negedge mclk);
            slot_req = 1'b0;
            b[i] = tx_valid ? tx_bit : 1'bx;
        end
    endtask
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// self-checking bench of the memory-function block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import spe_pkg::*;
    localparam int unsigned PC = 20;
    logic        mclk = 1'b0;
    logic        resetn = 1'b0;
    logic        func_start = 1'b0;
    logic        bus_reset = 1'b0, p_loss = 1'b0, c_fault = 1'b0;
    logic        fast_in = 1'b0;
    logic        rx_valid, rx_bit, rx_ready, slot_req, tx_bit, tx_valid, fast, busy;
    logic [7:0]  ta_lo, ta_hi, es, r, e;
    logic [15:0] c;
    int          n_errors = 0;
    int          checked = 0;
    initial forever #20 mclk = ~mclk;
    spe_memfunc #(.PROG_CYCLES(PC)) DUT (.mclk(mclk), .resetn(resetn), .func_start(func_start),
        .bus_reset(bus_reset), .fast_speed_in(fast_in), .rx_valid(rx_valid), .rx_bit(rx_bit),
        .rx_ready(rx_ready), .slot_req(slot_req), .tx_bit(tx_bit), .tx_valid(tx_valid),
        .power_loss(p_loss), .copy_fault(c_fault), .target_addr_low(ta_lo),
        .target_addr_high(ta_hi), .ending_offset_status(es), .fast_speed_flag(fast), .busy(busy));
    spe_master_model mst (.mclk(mclk), .rx_valid(rx_valid), .rx_bit(rx_bit),
        .rx_ready(rx_ready), .slot_req(slot_req), .tx_bit(tx_bit), .tx_valid(tx_valid));
    task automatic chk(input string n, input logic [15:0] x, input logic [15:0] s);
        checked++;
        if (s !== x) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic summarize();
        if (n_errors == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    function automatic logic [15:0] crc(input logic [15:0] v, input logic [7:0] b);
        for (int i = 0; i < 8; i++) v = (v[0] ^ b[i]) ? (v >> 1) ^ CRC_POLY : v >> 1;
        return v;
    endfunction
    task automatic start(input logic [7:0] cmd, input bit fs, input logic [7:0] lo, input bit ad);
        @(negedge mclk);
        bus_reset = 1'b1;
        @(negedge mclk);
        bus_reset = 1'b0;
        func_start = 1'b1;
        fast_in = fs;
        @(negedge mclk);
        func_start = 1'b0;
        mst.send(cmd, 8);
        if (ad) begin
            mst.send(lo, 8);
            mst.send(8'h00, 8);
        end
    endtask
    initial begin
        repeat (12) @(negedge mclk);
        resetn = 1'b1;
        chk("status", 16'h0020, {8'h00, es});
        c = crc(crc(crc(16'h0000, CMD_WRITE_SP), 8'h10), 8'h00);
        start(CMD_WRITE_SP, 1'b0, 8'h10, 1'b1);
        for (int i = 0; i < 8; i++) begin
            mst.send(8'h30 + 8'(i), 8);
            c = crc(c, 8'h30 + 8'(i));
        end
        mst.recv(r);
        mst.recv(e);
        chk("write crc", ~c, {e, r});
        chk("status", 16'h0007, {8'h00, es});
        start(CMD_READ_SP, 1'b0, 8'h00, 1'b0);
        c = 16'h0000;
        for (int i = 0; i < 11; i++) begin
            e = (i == 0) ? 8'h10 : (i == 1) ? 8'h00 : (i == 2) ? 8'h07 : 8'h2D + 8'(i);
            mst.recv(r);
            chk("scratch read", {8'h00, e}, {8'h00, r});
            c = crc(c, e);
        end
        mst.recv(r);
        mst.recv(e);
        chk("read crc", ~c, {e, r});
        mst.recv(r);
        chk("after crc", 16'h00FF, {8'h00, r});
        start(CMD_COPY_SP, 1'b0, 8'h10, 1'b1);
        mst.send(8'h07, 8);
        repeat (4) @(negedge mclk);
        chk("busy", 16'h0001, {15'h0, busy});
        repeat (PC + 4) @(negedge mclk);
        chk("status", 16'h0087, {8'h00, es});
        mst.recv(r);
        chk("after copy", 16'h00AA, {8'h00, r});
        start(CMD_READ_MEM, 1'b0, 8'h16, 1'b1);
        for (int i = 0; i < 3; i++) begin
            mst.recv(r);
            chk("memory", {8'h00, i < 2 ? 8'h36 + 8'(i) : 8'hFF}, {8'h00, r});
        end
        chk("address", 16'h0010, {ta_hi, ta_lo});
        start(CMD_WRITE_SP, 1'b1, 8'h03, 1'b1);
        mst.send(8'hA5, 8);
        mst.send(8'h5A, 8);
        mst.send(8'hFF, 3);
        start(CMD_COPY_SP, 1'b1, 8'h03, 1'b1);
        mst.send(8'h24, 8);
        chk("status", 16'h0024, {8'h00, es});
        chk("speed", 16'h0001, {15'h0, fast});
        mst.recv(r);
        chk("refused copy", 16'h00FF, {8'h00, r});
        start(CMD_WRITE_SP, 1'b0, 8'h18, 1'b1);
        for (int i = 0; i < 8; i++) mst.send(8'h40, 8);
        start(CMD_COPY_SP, 1'b0, 8'h18, 1'b1);
        mst.send(8'h07, 8);
        repeat (4) @(negedge mclk);
        {c_fault, p_loss} = 2'b11;
        @(negedge mclk);
        {c_fault, p_loss} = 2'b00;
        repeat (PC + 4) @(negedge mclk);
        chk("power loss", 16'h00A7, {8'h00, es});
        mst.recv(r);
        chk("faulted copy", 16'h00FF, {8'h00, r});
        summarize();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        summarize();
    end
endmodule
`default_nettype wire
